// >>> inc/dsb_map.svh
`ifndef DSB_MAP_SVH
`define DSB_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DSB_OFF_CTRL      8'h00
`define DSB_OFF_USER_LO   8'h04
`define DSB_OFF_USER_HI   8'h08
`define DSB_OFF_STATION   8'h0C
`define DSB_OFF_IDENT     8'h10
`define DSB_OFF_MSG       8'h14
`define DSB_OFF_IRQ_STS   8'h18
`define DSB_OFF_IRQ_MSK   8'h1C
`define DSB_OFF_STATUS    8'h20

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define DSB_CTRL_VALID    0
`define DSB_CTRL_DELETE   1
`define DSB_CTRL_BAD      2'h3
`define DSB_ST0_MASK      8'h5E
`define DSB_ST1_MASK      8'h3B
`define DSB_ST1_FIX       8'h04
`define DSB_ST2_OVF       7
`define DSB_LEN_CODE      8'h0A
`define DSB_LAST_IDX      4'hF
`define DSB_IRQ_DONE      0
`define DSB_IRQ_IGNORED   1
`define DSB_IRQ_ERRSEND   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSB_RST_BYTE      8'h00
`define DSB_RST_IDENT     16'h0000
`define DSB_RST_MSG       8'h00
`define DSB_RST_IRQ       3'h0

`endif

// >>> inc/dsb_pkg.sv
package dsb_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DSB_IDLE = 2'b01,
        DSB_SEND = 2'b10
    } dsb_fsm_e;

    typedef logic [2:0] dsb_irq_t;

    typedef struct packed {
        dsb_fsm_e    fsm;
        logic [3:0]  idx;
        logic [7:0]  tx_data;
        logic        pending;
        logic [1:0]  ctrl;
        logic [39:0] user;
        logic [7:0]  st0;
        logic [7:0]  st1;
        logic        ovf;
        logic [7:0]  maddr;
        logic [15:0] ident;
        logic [7:0]  msg;
        dsb_irq_t    irq_sts;
        dsb_irq_t    irq_msk;
        logic        poll_prev;
        logic        err_prev;
        logic [31:0] prdata;
    } dsb_state_s;

endpackage : dsb_pkg

// >>> rtl/dsb_diag_builder.sv
`timescale 1ns/1ns
`include "dsb_map.svh"

// ----------------------------------------------------------------------
// Slave diagnostic frame builder with APB register access
// ----------------------------------------------------------------------
module dsb_diag_builder
    import dsb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        diag_poll,
    input  wire logic        diag_error,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Known offsets answer normally; everything else gets an error.
    // Keeping one list here means the error response and the write
    // enable can never disagree about which offsets exist.
    function automatic logic dsb_known(input logic [7:0] a);
        unique case (a)
            `DSB_OFF_CTRL, `DSB_OFF_USER_LO, `DSB_OFF_USER_HI,
            `DSB_OFF_STATION, `DSB_OFF_IDENT, `DSB_OFF_MSG,
            `DSB_OFF_IRQ_STS, `DSB_OFF_IRQ_MSK,
            `DSB_OFF_STATUS: dsb_known = 1'b1;
            default:         dsb_known = 1'b0;
        endcase
    endfunction : dsb_known

    // True on the access edge of a write to the given offset.
    function automatic logic dsb_wr_hit(input logic       wr,
                                        input logic [7:0] a,
                                        input logic [7:0] off);
        dsb_wr_hit = wr && (a == off);
    endfunction : dsb_wr_hit

    // Registered state, its next value and the wires between the parts.
    dsb_state_s  s_q;
    dsb_state_s  s_d;
    logic [1:0]  pin_sync;
    logic        poll_s;
    logic        err_s;
    logic [3:0]  sel_idx;
    logic [7:0]  sel_byte;
    logic        wr_en;
    logic        rd_setup;
    logic        busy;

    // ------------------------------------------------------------------
    // Pin synchronisation and byte selection
    // ------------------------------------------------------------------

    // Poll and error arrive from outside the clock domain.
    // Both stages sit in the shared synchroniser so nothing in this
    // module can read a half-settled pin level.
    dsb_sync2 #(
        .W (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({diag_error, diag_poll}),
        .sync_out (pin_sync)
    );

    // Bit 0 carries the poll pin and bit 1 the error pin.
    assign poll_s = pin_sync[0];
    assign err_s  = pin_sync[1];

    // The byte to load next: byte 0 from idle, else the following one.
    // Wrapping past 15 is harmless: the sequencer stops at the last byte.
    assign sel_idx = (s_q.fsm == DSB_SEND) ? 4'(s_q.idx + 4'h1) : 4'h0;

    dsb_frame_byte u_byte (
        .idx      (sel_idx),
        .st0      (s_q.st0),
        .st1      (s_q.st1),
        .ovf      (s_q.ovf),
        .maddr    (s_q.maddr),
        .ident    (s_q.ident),
        .msg      (s_q.msg),
        .user     (s_q.user),
        .byte_out (sel_byte)
    );

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------

    // Zero wait states: every access phase completes in one cycle.
    // The trade-off is that read data must already be registered, which
    // is why it is captured during the setup phase below.
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !dsb_known(paddr);
    assign wr_en    = psel && penable && pwrite && dsb_known(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // One process works out the whole next state: triggers, register
    // writes, the frame sequencer, sticky flags and read capture. Every
    // field starts from its current value, so nothing is latched.
    always_comb begin
        logic     cpu_trig;
        logic     ext_trig;
        logic     trig;
        logic     del;
        logic     bad;
        logic     done;
        logic     err_rise;
        dsb_irq_t set_bits;
        dsb_irq_t clr_bits;
        cpu_trig = 1'b0;
        ext_trig = 1'b0;
        trig     = 1'b0;
        del      = 1'b0;
        bad      = 1'b0;
        done     = 1'b0;
        err_rise = 1'b0;
        set_bits = '0;
        clr_bits = '0;
        s_d      = s_q;

        // Edges of the synchronised pins.
        // The previous levels reset low, matching the idle pins, so no
        // false trigger follows reset.
        s_d.poll_prev = poll_s;
        s_d.err_prev  = err_s;
        err_rise      = err_s && !s_q.err_prev;
        ext_trig      = (poll_s && !s_q.poll_prev) || err_rise;

        // Control byte: the both-bits value is dropped whole.
        // Only a rising valid bit starts a send; rewriting one while it is
        // already set does nothing.
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_CTRL)) begin
            if (pwdata[1:0] == `DSB_CTRL_BAD) begin
                bad = 1'b1;
            end else begin
                s_d.ctrl = pwdata[1:0];
                del      = pwdata[`DSB_CTRL_DELETE];
                cpu_trig = pwdata[`DSB_CTRL_VALID]
                           && !s_q.ctrl[`DSB_CTRL_VALID];
            end
        end
        trig = cpu_trig || ext_trig;

        // Software-owned frame contents.
        // Reserved bits are masked on the way in as well as on the way out.
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_USER_LO)) begin
            s_d.user[31:0] = pwdata;
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_USER_HI)) begin
            s_d.user[39:32] = pwdata[7:0];
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_STATION)) begin
            s_d.st0 = pwdata[7:0] & `DSB_ST0_MASK;
            s_d.st1 = pwdata[15:8] & `DSB_ST1_MASK;
            s_d.ovf = pwdata[16+`DSB_ST2_OVF];
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_IDENT)) begin
            s_d.maddr = pwdata[7:0];
            s_d.ident = pwdata[31:16];
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_MSG)) begin
            s_d.msg = pwdata[7:0];
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_IRQ_MSK)) begin
            s_d.irq_msk = pwdata[2:0];
        end
        if (dsb_wr_hit(wr_en, paddr, `DSB_OFF_IRQ_STS)) begin
            clr_bits = pwdata[2:0];
        end

        // Delete drops a queued request; a trigger in the same cycle
        // still queues, so a fresh start is never lost.
        if (del) begin
            s_d.pending = 1'b0;
        end

        // Frame sequencer: sixteen bytes, index 0 first.
        // Each byte is loaded when it becomes current, so software changes
        // made mid-frame show up only in bytes not yet loaded.
        unique case (s_q.fsm)
            DSB_IDLE: begin
                if (trig || (s_q.pending && !del)) begin
                    s_d.fsm     = DSB_SEND;
                    s_d.idx     = 4'h0;
                    s_d.tx_data = sel_byte;
                    s_d.pending = 1'b0;
                end
            end
            DSB_SEND: begin
                if (trig) begin
                    s_d.pending = 1'b1;
                end
                if (tx_ready) begin
                    if (s_q.idx == `DSB_LAST_IDX) begin
                        s_d.fsm = DSB_IDLE;
                        done    = 1'b1;
                    end else begin
                        s_d.idx     = sel_idx;
                        s_d.tx_data = sel_byte;
                    end
                end
            end
            // A corrupted state code falls back to idle rather than
            // leaving the link stuck in a code that never raises valid.
            default: begin
                s_d.fsm = DSB_IDLE;
                s_d.idx = 4'h0;
            end
        endcase

        // Sticky events; a new event wins over a clear in the same cycle.
        // Software therefore cannot lose an event by clearing too late.
        set_bits[`DSB_IRQ_DONE]    = done;
        set_bits[`DSB_IRQ_IGNORED] = bad;
        set_bits[`DSB_IRQ_ERRSEND] = err_rise;
        s_d.irq_sts = (s_q.irq_sts & ~clr_bits) | set_bits;

        // Read data is captured in the setup phase so it is a flop.
        // It then stands unchanged through the access phase and until the
        // next read setup, whatever the state does meanwhile.
        if (rd_setup) begin
            unique case (paddr)
                `DSB_OFF_CTRL:    s_d.prdata = {30'h0, s_q.ctrl};
                `DSB_OFF_USER_LO: s_d.prdata = s_q.user[31:0];
                `DSB_OFF_USER_HI: s_d.prdata = {24'h0, s_q.user[39:32]};
                `DSB_OFF_STATION: s_d.prdata = {8'h00, s_q.ovf, 7'h00,
                                                s_q.st1, s_q.st0};
                `DSB_OFF_IDENT:   s_d.prdata = {s_q.ident, 8'h00,
                                                s_q.maddr};
                `DSB_OFF_MSG:     s_d.prdata = {24'h0, s_q.msg};
                `DSB_OFF_IRQ_STS: s_d.prdata = {29'h0, s_q.irq_sts};
                `DSB_OFF_IRQ_MSK: s_d.prdata = {29'h0, s_q.irq_msk};
                `DSB_OFF_STATUS:  s_d.prdata = {26'h0,
                                                busy,
                                                s_q.pending, s_q.idx};
                default:          s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Reset loads constants only; the whole state is one register so
    // every field moves on the same edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.fsm       <= DSB_IDLE;
            s_q.idx       <= 4'h0;
            s_q.tx_data   <= `DSB_RST_BYTE;
            s_q.pending   <= 1'b0;
            s_q.ctrl      <= 2'h0;
            s_q.user      <= 40'h00_0000_0000;
            s_q.st0       <= `DSB_RST_BYTE;
            s_q.st1       <= `DSB_RST_BYTE;
            s_q.ovf       <= 1'b0;
            s_q.maddr     <= `DSB_RST_BYTE;
            s_q.ident     <= `DSB_RST_IDENT;
            s_q.msg       <= `DSB_RST_MSG;
            s_q.irq_sts   <= `DSB_RST_IRQ;
            s_q.irq_msk   <= `DSB_RST_IRQ;
            s_q.poll_prev <= 1'b0;
            s_q.err_prev  <= 1'b0;
            s_q.prdata    <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Busy is decoded once and shared by the link and the status word.
    assign busy     = (s_q.fsm == DSB_SEND);

    // Frame bytes are flops; valid and last follow the sequencer.
    // Valid is a decode of the state register, so it changes only on a
    // clock edge.
    assign tx_valid = busy;
    assign tx_data  = s_q.tx_data;
    assign tx_last  = tx_valid && (s_q.idx == `DSB_LAST_IDX);
    assign prdata   = s_q.prdata;
    assign irq      = |(s_q.irq_sts & s_q.irq_msk);

endmodule : dsb_diag_builder

// >>> rtl/dsb_frame_byte.sv
`timescale 1ns/1ns
`include "dsb_map.svh"

// ----------------------------------------------------------------------
// Selects one byte of the diagnostic frame by its index
// ----------------------------------------------------------------------
module dsb_frame_byte
    import dsb_pkg::*;
(
    input  wire logic [3:0]  idx,
    input  wire logic [7:0]  st0,
    input  wire logic [7:0]  st1,
    input  wire logic        ovf,
    input  wire logic [7:0]  maddr,
    input  wire logic [15:0] ident,
    input  wire logic [7:0]  msg,
    input  wire logic [39:0] user,
    output logic      [7:0]  byte_out
);

    // Fixed bits are forced here so stored flags can never leak into them.
    always_comb begin
        unique case (idx)
            4'h0: byte_out = st0 & `DSB_ST0_MASK;
            4'h1: byte_out = (st1 & `DSB_ST1_MASK) | `DSB_ST1_FIX;
            4'h2: byte_out = {ovf, 7'h00};
            4'h3: byte_out = maddr;
            4'h4: byte_out = ident[15:8];
            4'h5: byte_out = ident[7:0];
            4'h6: byte_out = `DSB_LEN_CODE;
            4'h7: byte_out = msg;
            4'h8, 4'h9, 4'hA: byte_out = `DSB_RST_BYTE;
            4'hB: byte_out = user[7:0];
            4'hC: byte_out = user[15:8];
            4'hD: byte_out = user[23:16];
            4'hE: byte_out = user[31:24];
            4'hF: byte_out = user[39:32];
        endcase
    end

endmodule : dsb_frame_byte

// >>> rtl/dsb_sync2.sv
`timescale 1ns/1ns
`include "dsb_map.svh"

// ----------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------
module dsb_sync2
    import dsb_pkg::*;
#(
    parameter int W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // The first stage feeds only the second, giving it a cycle to settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : dsb_sync2

// >>> verification/dsb_diag_builder_sva.sv
`timescale 1ns/1ns
// --------------------
// Frame and trigger checker
// --------------------
module dsb_diag_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic        diag_poll
);
    logic [3:0] idx_q;
    logic       vld_q;
    wire        ctl_wr = psel && penable && pwrite && paddr == 8'h00;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Byte position in the frame and the last accepted valid bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 4'h0;
            vld_q <= 1'b0;
        end else begin
            if (tx_valid && tx_ready)
                idx_q <= tx_last ? 4'h0 : idx_q + 4'h1;
            if (ctl_wr && pwdata[1:0] != 2'h3)
                vld_q <= pwdata[0];
        end
    end

    chk_last_pos: assert property (
        tx_valid |-> tx_last == (idx_q == 4'hF))
        else $error("tx_last not on byte 15");
    chk_byte_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed before handshake");
    chk_st0_fixed: assert property (
        tx_valid && idx_q == 4'h0 |-> (tx_data & 8'hA1) == 8'h00)
        else $error("byte 0 fixed bits wrong");
    chk_st1_fixed: assert property (
        tx_valid && idx_q == 4'h1 |-> (tx_data & 8'hC4) == 8'h04)
        else $error("byte 1 fixed bits wrong");
    chk_st2_rsvd: assert property (
        tx_valid && idx_q == 4'h2 |-> tx_data[6:0] == 7'h00)
        else $error("byte 2 reserved bits set");
    chk_len_code: assert property (
        tx_valid && idx_q == 4'h6 |-> tx_data == 8'h0A)
        else $error("byte 6 length code wrong");
    chk_rsvd_bytes: assert property (
        tx_valid && idx_q inside {4'h8, 4'h9, 4'hA} |-> tx_data == 8'h00)
        else $error("reserved byte not zero");
    chk_poll_send: assert property (
        $rose(diag_poll) && !tx_valid |-> ##[1:6] tx_valid)
        else $error("poll did not start a frame");
    chk_cpu_start: assert property (
        ctl_wr && pwdata[1:0] == 2'h1 && !vld_q && !tx_valid |=> tx_valid)
        else $error("valid rise did not start a frame");
    chk_bad_ignored: assert property (
        ctl_wr && pwdata[1:0] == 2'h3 && !tx_valid |=> !tx_valid)
        else $error("control value 3 started a frame");
endmodule : dsb_diag_sva

// >>> verification/dsb_master_model.sv
`timescale 1ns/1ns
// --------------------
// Bus master side: polls, error events, byte acceptance
// --------------------
module dsb_master_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic poll_req,
    input wire logic err_req,
    output logic     tx_ready,
    output logic     diag_poll,
    output logic     diag_error
);
    // Pins change only after an edge; a stalled master takes one byte
    // in four so the frame holds its byte across waits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready   <= 1'b0;
            diag_poll  <= 1'b0;
            diag_error <= 1'b0;
        end else begin
            diag_poll  <= poll_req;
            diag_error <= err_req;
            tx_ready   <= stall ? ($urandom_range(3) == 0) : 1'b1;
        end
    end
endmodule : dsb_master_model

// >>> verification/tb_top.sv
`timescale 1ns/1ns
// --------------------
// Testbench top
// --------------------
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, stall = 0, poll_req = 0, err_req = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, st, id, ulo, uhi, rdat;
    logic        pready, pslverr, diag_poll, diag_error, serr;
    logic        tx_valid, tx_last, tx_ready, irq;
    logic [7:0]  tx_data, exp_b;
    logic [7:0]  codes [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                               8'h17, 8'h40};
    logic [7:0]  q [$];
    int          mismatches = 0, checks_done = 0;

    always #10 pclk = ~pclk;

    dsb_diag_builder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .diag_poll(diag_poll),
        .diag_error(diag_error), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq));

    dsb_master_model u_mst (.pclk(pclk), .presetn(presetn),
        .stall(stall), .poll_req(poll_req), .err_req(err_req),
        .tx_ready(tx_ready), .diag_poll(diag_poll),
        .diag_error(diag_error));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize();
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // One APB transfer; the request is held until pready is sampled.
    // Only the watchdog ends a wait that never finishes.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rd

    // Expected frame from the shadow copies of what software wrote.
    task automatic push_frame(input logic [7:0] m);
        logic [7:0] f [16];
        f = '{st[7:0] & 8'h5E, (st[15:8] & 8'h3B) | 8'h04,
              {st[23], 7'h00}, id[7:0], id[31:24], id[23:16], 8'h0A, m,
              8'h00, 8'h00, 8'h00, ulo[7:0], ulo[15:8], ulo[23:16],
              ulo[31:24], uhi[7:0]};
        foreach (f[i]) q.push_back(f[i]);
    endtask : push_frame

    // Waits for the frame to drain, then checks and clears the flags.
    task automatic done_chk(input logic [31:0] sts);
        while (q.size() != 0 || tx_valid !== 1'b0) begin
            @(posedge pclk);
        end
        @(posedge pclk);
        chk("irq_set", 1, irq);
        rd(8'h18, sts, "irq_sts");
        apb(1'b1, 8'h18, 32'h7);
        @(posedge pclk);
        chk("irq_clear", 0, irq);
    endtask : done_chk

    // Every accepted byte is matched against the oldest expectation.
    always @(posedge pclk) begin
        if (presetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (q.size() == 0)
                chk("unexpected_byte", 32'h1FF, {24'h0, tx_data});
            else begin
                exp_b = q.pop_front();
                chk("frame_byte", exp_b, tx_data);
            end
        end
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        summarize();
    end

    initial begin
        void'($urandom(32'h1A3226DC));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h18, 32'h0, "irq_sts_reset");
        rd(8'h40, 32'h0, "unmapped_data");
        chk("unmapped_err", 1, serr);
        st = $urandom;
        id = $urandom;
        uhi = $urandom & 32'hFF;
        apb(1'b1, 8'h0C, st);
        apb(1'b1, 8'h10, id);
        apb(1'b1, 8'h08, uhi);
        apb(1'b1, 8'h1C, 32'h7);
        foreach (codes[i]) begin
            stall <= i[0];
            ulo = $urandom;
            apb(1'b1, 8'h04, ulo);
            rd(8'h04, ulo, "user_lo");
            chk("user_lo_err", 0, serr);
            apb(1'b1, 8'h14, {24'h0, codes[i]});
            push_frame(codes[i]);
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h00, 32'h1);
            done_chk(32'h1);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h3);
        repeat (10) @(posedge pclk);
        rd(8'h18, 32'h2, "ignored_flag");
        chk("irq_ignored", 1, irq);
        apb(1'b1, 8'h1C, 32'h1);
        @(posedge pclk);
        chk("irq_masked", 0, irq);
        apb(1'b1, 8'h1C, 32'h7);
        apb(1'b1, 8'h18, 32'h7);
        stall <= 1'b1;
        push_frame(8'h40);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h2);
        done_chk(32'h1);
        repeat (40) @(posedge pclk);
        chk("no_second_frame", 0, tx_valid);
        rd(8'h20, 32'hF, "status_idle");
        push_frame(8'h40);
        poll_req <= 1'b1;
        repeat (4) @(posedge pclk);
        poll_req <= 1'b0;
        done_chk(32'h1);
        push_frame(8'h40);
        err_req <= 1'b1;
        repeat (4) @(posedge pclk);
        err_req <= 1'b0;
        done_chk(32'h5);
        summarize();
    end
endmodule : tb_top

bind dsb_diag_builder dsb_diag_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .diag_poll(diag_poll));
